/* File: src/jcp_pkg.sv */
// Contract
// - Programming only via four-wire serial test port
// - Configuration kept in nonvolatile cells
// - 32-bit user signature word, freely writable; code writes it only after the programming-enable instruction
// - Readout lock blocks configuration readback
// - Lock cleared only by whole-device erase
// - One port for programming and boundary scan
// - Mode-stepped controller loads instruction register
// - Address, shift data, then program commits
// - Bypass and boundary-scan data registers provided
// - Sample inputs rising, drive output falling
// - Eight-bit instructions; msb one selects bypass
// - Code 0000 1001 sets readout lock
// - Codes 0001 0111 read, 0001 1010 write signature
package jcp_pkg;

  // ----------------------------------------
  // Widths and depths
  // ----------------------------------------
  localparam int IR_LEN = 8;
  localparam int ADDR_LEN = 10;
  localparam int COL_LEN = 89;
  localparam int SIG_LEN = 32;
  localparam int BSR_LEN = 8;
  localparam int NUM_COLS = 1024;
  localparam int BUF_DEPTH = 2;

  // ----------------------------------------
  // Instruction codes
  // ----------------------------------------
  localparam logic [7:0] I_EXTEST = 8'h00;
  localparam logic [7:0] I_ADDR = 8'h01;
  localparam logic [7:0] I_DATA = 8'h02;
  localparam logic [7:0] I_ERASE = 8'h03;
  localparam logic [7:0] I_PROG = 8'h07;
  localparam logic [7:0] I_LOCK = 8'h09;
  localparam logic [7:0] I_VERIFY = 8'h0a;
  localparam logic [7:0] I_PEN = 8'h15;
  localparam logic [7:0] I_IDCODE = 8'h16;
  localparam logic [7:0] I_SIG_RD = 8'h17;
  localparam logic [7:0] I_SIG_WR = 8'h1a;
  localparam logic [7:0] I_SAMPLE = 8'h1c;
  localparam logic [7:0] I_PDIS = 8'h1e;
  localparam logic [7:0] I_INTEST = 8'h2c;
  localparam logic [7:0] I_PROG_INC = 8'h27;
  localparam logic [7:0] I_VER_INC = 8'h2a;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] IR_RST = I_IDCODE;
  localparam logic [31:0] ID_VALUE = 32'h0000_a001; // Arbitrary value
  localparam logic [9:0] ERASE_LAST = 10'h3ff;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [3:0] {
    S_TLR, S_RTI, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PA_DR, S_EX2_DR,
    S_UPD_DR, S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PA_IR, S_EX2_IR, S_UPD_IR
  } jcp_tap_e;

  typedef enum logic [2:0] {
    OP_NONE, OP_PROG, OP_VERIFY, OP_LOCK, OP_ERASE, OP_SIG_RD, OP_SIG_WR
  } jcp_op_e;

  typedef enum logic [2:0] {
    DR_BYP, DR_BSR, DR_ID, DR_ADDR, DR_DATA, DR_SIG
  } jcp_dr_e;

  typedef struct packed {
    jcp_op_e op;
    logic incr;
    logic [ADDR_LEN-1:0] addr;
    logic [COL_LEN-1:0] data;
  } jcp_req_s;

endpackage

/* File: src/jcp_port.sv */
`timescale 1ns/1ns
`default_nettype none
module jcp_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [jcp_pkg::BSR_LEN-1:0] pins_in,
  output logic [jcp_pkg::BSR_LEN-1:0] pins_out,
  output logic readout_lock_bit,
  output logic [jcp_pkg::SIG_LEN-1:0] user_signature_word,
  output logic nv_busy
);

  // ----------------------------------------
  // State types
  // ----------------------------------------
  typedef struct packed {
    jcp_pkg::jcp_tap_e st;
    logic [jcp_pkg::IR_LEN-1:0] ir;
    logic [jcp_pkg::IR_LEN-1:0] ir_sr;
    logic byp;
    logic [jcp_pkg::BSR_LEN-1:0] bsr_sr;
    logic [jcp_pkg::BSR_LEN-1:0] bsr_upd;
    logic [jcp_pkg::BSR_LEN-1:0] pin_s1;
    logic [jcp_pkg::BSR_LEN-1:0] pin_s2;
    logic [31:0] id_sr;
    logic [jcp_pkg::ADDR_LEN-1:0] addr_sr;
    logic [jcp_pkg::COL_LEN-1:0] data_sr;
    logic [jcp_pkg::SIG_LEN-1:0] sig_sr;
    logic prog_en;
    logic req_tgl;
    jcp_pkg::jcp_req_s req;
    logic pending;
    logic rsp_s1;
    logic rsp_s2;
    logic rsp_seen;
  } jcp_tck_s;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic erasing;
    logic [jcp_pkg::ADDR_LEN-1:0] ecnt;
    logic [jcp_pkg::BUF_DEPTH-1:0][jcp_pkg::COL_LEN-1:0] fifo;
    logic [1:0] fcnt;
    logic rsp_tgl;
    logic rsp_open;
    logic [jcp_pkg::COL_LEN-1:0] rsp_data;
  } jcp_clk_s;

  jcp_tck_s t_reg, t_next;
  jcp_clk_s c_reg, c_next;
  logic [1:0] trst_sync;
  logic [1:0] crst_sync;
  logic tck_rst_n, clk_rst_n;
  logic tdo_bit, shifting;
  logic [jcp_pkg::COL_LEN-1:0] nv_cols [jcp_pkg::NUM_COLS];
  logic nv_lock = 1'b0;
  logic [jcp_pkg::SIG_LEN-1:0] nv_sig = 32'h0000_0000;
  logic nv_we, lock_set, lock_clr, sig_we;
  logic [jcp_pkg::ADDR_LEN-1:0] nv_addr;
  logic [jcp_pkg::COL_LEN-1:0] nv_wdata;
  logic [jcp_pkg::SIG_LEN-1:0] sig_wdata;
  logic [jcp_pkg::COL_LEN-1:0] push_data;
  logic push;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Data register chosen by an instruction
  function automatic jcp_pkg::jcp_dr_e dr_of(input logic [7:0] ir);
    jcp_pkg::jcp_dr_e d;
    d = jcp_pkg::DR_BYP;
    if (ir[7]) begin
      d = jcp_pkg::DR_BYP;
    end else begin
      case (ir)
        jcp_pkg::I_EXTEST, jcp_pkg::I_SAMPLE, jcp_pkg::I_INTEST: d = jcp_pkg::DR_BSR;
        jcp_pkg::I_IDCODE: d = jcp_pkg::DR_ID;
        jcp_pkg::I_ADDR: d = jcp_pkg::DR_ADDR;
        jcp_pkg::I_DATA: d = jcp_pkg::DR_DATA;
        jcp_pkg::I_SIG_RD, jcp_pkg::I_SIG_WR: d = jcp_pkg::DR_SIG;
        default: d = jcp_pkg::DR_BYP;
      endcase
    end
    return d;
  endfunction

  // Storage operation started by an instruction
  function automatic jcp_pkg::jcp_op_e op_of(input logic [7:0] ir, input logic en);
    jcp_pkg::jcp_op_e o;
    o = jcp_pkg::OP_NONE;
    case (ir)
      jcp_pkg::I_PROG, jcp_pkg::I_PROG_INC: o = en ? jcp_pkg::OP_PROG : jcp_pkg::OP_NONE;
      jcp_pkg::I_VERIFY, jcp_pkg::I_VER_INC: o = jcp_pkg::OP_VERIFY;
      jcp_pkg::I_LOCK: o = en ? jcp_pkg::OP_LOCK : jcp_pkg::OP_NONE;
      jcp_pkg::I_ERASE: o = en ? jcp_pkg::OP_ERASE : jcp_pkg::OP_NONE;
      jcp_pkg::I_SIG_RD: o = jcp_pkg::OP_SIG_RD;
      jcp_pkg::I_SIG_WR: o = en ? jcp_pkg::OP_SIG_WR : jcp_pkg::OP_NONE;
      default: o = jcp_pkg::OP_NONE;
    endcase
    return o;
  endfunction

  // ----------------------------------------
  // Reset release per domain
  // ----------------------------------------
  // Two-stage release of the reset on the link clock
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      trst_sync <= 2'h0;
    end else begin
      trst_sync <= {trst_sync[0], 1'b1};
    end
  end

  // Two-stage release of the reset on the system clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crst_sync <= 2'h0;
    end else begin
      crst_sync <= {crst_sync[0], 1'b1};
    end
  end

  assign tck_rst_n = trst_sync[1];
  assign clk_rst_n = crst_sync[1];

  // ----------------------------------------
  // Link side: controller and shift paths
  // ----------------------------------------
  // Next state of everything on the test clock
  always_comb begin
    t_next = t_reg;
    t_next.pin_s1 = pins_in;
    t_next.pin_s2 = t_reg.pin_s1;
    t_next.rsp_s1 = c_reg.rsp_tgl;
    t_next.rsp_s2 = t_reg.rsp_s1;
    // Completion of a storage operation
    if (t_reg.pending && (t_reg.rsp_s2 != t_reg.rsp_seen)) begin
      t_next.rsp_seen = t_reg.rsp_s2;
      t_next.pending = 1'b0;
      case (t_reg.req.op)
        jcp_pkg::OP_VERIFY: t_next.data_sr = c_reg.rsp_data;
        jcp_pkg::OP_SIG_RD: t_next.sig_sr = c_reg.rsp_data[jcp_pkg::SIG_LEN-1:0];
        default: t_next.data_sr = t_reg.data_sr;
      endcase
      if (t_reg.req.incr) begin
        t_next.addr_sr = t_reg.addr_sr + 10'h001;
      end
    end
    // Controller stepped by the mode input
    case (t_reg.st)
      jcp_pkg::S_TLR: t_next.st = tms ? jcp_pkg::S_TLR : jcp_pkg::S_RTI;
      jcp_pkg::S_RTI: t_next.st = tms ? jcp_pkg::S_SEL_DR : jcp_pkg::S_RTI;
      jcp_pkg::S_SEL_DR: t_next.st = tms ? jcp_pkg::S_SEL_IR : jcp_pkg::S_CAP_DR;
      jcp_pkg::S_CAP_DR: t_next.st = tms ? jcp_pkg::S_EX1_DR : jcp_pkg::S_SH_DR;
      jcp_pkg::S_SH_DR: t_next.st = tms ? jcp_pkg::S_EX1_DR : jcp_pkg::S_SH_DR;
      jcp_pkg::S_EX1_DR: t_next.st = tms ? jcp_pkg::S_UPD_DR : jcp_pkg::S_PA_DR;
      jcp_pkg::S_PA_DR: t_next.st = tms ? jcp_pkg::S_EX2_DR : jcp_pkg::S_PA_DR;
      jcp_pkg::S_EX2_DR: t_next.st = tms ? jcp_pkg::S_UPD_DR : jcp_pkg::S_SH_DR;
      jcp_pkg::S_UPD_DR: t_next.st = tms ? jcp_pkg::S_SEL_DR : jcp_pkg::S_RTI;
      jcp_pkg::S_SEL_IR: t_next.st = tms ? jcp_pkg::S_TLR : jcp_pkg::S_CAP_IR;
      jcp_pkg::S_CAP_IR: t_next.st = tms ? jcp_pkg::S_EX1_IR : jcp_pkg::S_SH_IR;
      jcp_pkg::S_SH_IR: t_next.st = tms ? jcp_pkg::S_EX1_IR : jcp_pkg::S_SH_IR;
      jcp_pkg::S_EX1_IR: t_next.st = tms ? jcp_pkg::S_UPD_IR : jcp_pkg::S_PA_IR;
      jcp_pkg::S_PA_IR: t_next.st = tms ? jcp_pkg::S_EX2_IR : jcp_pkg::S_PA_IR;
      jcp_pkg::S_EX2_IR: t_next.st = tms ? jcp_pkg::S_UPD_IR : jcp_pkg::S_SH_IR;
      jcp_pkg::S_UPD_IR: t_next.st = tms ? jcp_pkg::S_SEL_DR : jcp_pkg::S_RTI;
      default: t_next.st = jcp_pkg::S_TLR;
    endcase
    // Actions of the present state
    case (t_reg.st)
      jcp_pkg::S_TLR: begin
        t_next.ir = jcp_pkg::IR_RST;
        t_next.prog_en = 1'b0;
      end
      jcp_pkg::S_CAP_IR: t_next.ir_sr = jcp_pkg::I_IDCODE;
      jcp_pkg::S_SH_IR: t_next.ir_sr = {tdi, t_reg.ir_sr[7:1]};
      jcp_pkg::S_UPD_IR: begin
        t_next.ir = t_reg.ir_sr;
        if (t_reg.ir_sr == jcp_pkg::I_PEN) begin
          t_next.prog_en = 1'b1;
        end else if (t_reg.ir_sr == jcp_pkg::I_PDIS) begin
          t_next.prog_en = 1'b0;
        end
      end
      jcp_pkg::S_CAP_DR: begin
        case (dr_of(t_reg.ir))
          jcp_pkg::DR_BYP: t_next.byp = 1'b0;
          jcp_pkg::DR_BSR: t_next.bsr_sr = t_reg.pin_s2;
          jcp_pkg::DR_ID: t_next.id_sr = jcp_pkg::ID_VALUE;
          default: t_next.byp = t_reg.byp;
        endcase
      end
      jcp_pkg::S_SH_DR: begin
        case (dr_of(t_reg.ir))
          jcp_pkg::DR_BYP: t_next.byp = tdi;
          jcp_pkg::DR_BSR: t_next.bsr_sr = {tdi, t_reg.bsr_sr[jcp_pkg::BSR_LEN-1:1]};
          jcp_pkg::DR_ID: t_next.id_sr = {tdi, t_reg.id_sr[31:1]};
          jcp_pkg::DR_ADDR: t_next.addr_sr = {tdi, t_reg.addr_sr[jcp_pkg::ADDR_LEN-1:1]};
          jcp_pkg::DR_DATA: t_next.data_sr = {tdi, t_reg.data_sr[jcp_pkg::COL_LEN-1:1]};
          jcp_pkg::DR_SIG: t_next.sig_sr = {tdi, t_reg.sig_sr[jcp_pkg::SIG_LEN-1:1]};
          default: t_next.byp = t_reg.byp;
        endcase
      end
      jcp_pkg::S_UPD_DR: begin
        if (dr_of(t_reg.ir) == jcp_pkg::DR_BSR) begin
          t_next.bsr_upd = t_reg.bsr_sr;
        end
      end
      default: t_next.ir = t_reg.ir;
    endcase
    // Launch a storage operation on entry to idle
    if ((t_reg.st == jcp_pkg::S_UPD_DR || t_reg.st == jcp_pkg::S_UPD_IR) && !tms
        && !t_reg.pending && op_of(t_next.ir, t_next.prog_en) != jcp_pkg::OP_NONE) begin
      t_next.req.op = op_of(t_next.ir, t_next.prog_en);
      t_next.req.incr = (t_next.ir == jcp_pkg::I_PROG_INC) || (t_next.ir == jcp_pkg::I_VER_INC);
      t_next.req.addr = t_next.addr_sr;
      t_next.req.data = (t_next.ir == jcp_pkg::I_SIG_WR)
        ? {57'h0, t_next.sig_sr} : t_next.data_sr;
      t_next.pending = 1'b1;
      t_next.req_tgl = ~t_reg.req_tgl;
    end
  end

  // Link-side state register, inputs sampled on the rising edge
  always_ff @(posedge tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      t_reg <= '{st: jcp_pkg::S_TLR, ir: jcp_pkg::IR_RST, default: '0};
    end else begin
      t_reg <= t_next;
    end
  end

  // Serial output selection
  always_comb begin
    shifting = (t_reg.st == jcp_pkg::S_SH_DR) || (t_reg.st == jcp_pkg::S_SH_IR);
    tdo_bit = 1'b0;
    if (t_reg.st == jcp_pkg::S_SH_IR) begin
      tdo_bit = t_reg.ir_sr[0];
    end else begin
      case (dr_of(t_reg.ir))
        jcp_pkg::DR_BYP: tdo_bit = t_reg.byp;
        jcp_pkg::DR_BSR: tdo_bit = t_reg.bsr_sr[0];
        jcp_pkg::DR_ID: tdo_bit = t_reg.id_sr[0];
        jcp_pkg::DR_ADDR: tdo_bit = t_reg.addr_sr[0];
        jcp_pkg::DR_DATA: tdo_bit = t_reg.data_sr[0];
        jcp_pkg::DR_SIG: tdo_bit = t_reg.sig_sr[0];
        default: tdo_bit = 1'b0;
      endcase
    end
  end

  // Serial output changes on the falling edge
  always_ff @(negedge tck or negedge tck_rst_n) begin
    if (!tck_rst_n) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      tdo <= shifting & tdo_bit;
      tdo_oe <= shifting;
    end
  end

  assign pins_out = t_reg.bsr_upd;

  // ----------------------------------------
  // Storage side: operations and reply buffer
  // ----------------------------------------
  // Next state on the system clock
  always_comb begin
    c_next = c_reg;
    c_next.req_s1 = t_reg.req_tgl;
    c_next.req_s2 = c_reg.req_s1;
    nv_we = 1'b0;
    nv_addr = t_reg.req.addr;
    nv_wdata = t_reg.req.data;
    lock_set = 1'b0;
    lock_clr = 1'b0;
    sig_we = 1'b0;
    sig_wdata = t_reg.req.data[jcp_pkg::SIG_LEN-1:0];
    push = 1'b0;
    push_data = '0;
    if (c_reg.erasing) begin
      // Whole-device erase walks every column
      nv_we = 1'b1;
      nv_addr = c_reg.ecnt;
      nv_wdata = '0;
      c_next.ecnt = c_reg.ecnt + 10'h001;
      if (c_reg.ecnt == jcp_pkg::ERASE_LAST) begin
        c_next.erasing = 1'b0;
        lock_clr = 1'b1;
        sig_we = 1'b1;
        sig_wdata = '0;
        push = 1'b1;
      end
    end else if ((c_reg.req_s2 != c_reg.req_seen) && (c_reg.fcnt < 2'h2)) begin
      c_next.req_seen = c_reg.req_s2;
      c_next.rsp_open = 1'b0;
      push = (t_reg.req.op != jcp_pkg::OP_ERASE);
      case (t_reg.req.op)
        jcp_pkg::OP_PROG: nv_we = 1'b1;
        jcp_pkg::OP_VERIFY: push_data = nv_lock ? '0 : nv_cols[t_reg.req.addr];
        jcp_pkg::OP_LOCK: lock_set = 1'b1;
        jcp_pkg::OP_SIG_RD: push_data = {57'h0, nv_sig};
        jcp_pkg::OP_SIG_WR: sig_we = 1'b1;
        jcp_pkg::OP_ERASE: begin
          c_next.erasing = 1'b1;
          c_next.ecnt = '0;
        end
        default: push = 1'b1;
      endcase
    end
    // Drain one reply toward the link when the slot is free
    if (c_reg.fcnt != 2'h0 && !c_reg.rsp_open) begin
      c_next.rsp_data = c_reg.fifo[0];
      c_next.rsp_tgl = ~c_reg.rsp_tgl;
      c_next.rsp_open = 1'b1;
      c_next.fifo[0] = c_reg.fifo[1];
      c_next.fcnt = c_reg.fcnt - 2'h1;
    end
    // Fill behind whatever was drained
    if (push) begin
      c_next.fifo[c_next.fcnt[0]] = push_data;
      c_next.fcnt = c_next.fcnt + 2'h1;
    end
  end

  // Storage-side state register
  always_ff @(posedge clk or negedge clk_rst_n) begin
    if (!clk_rst_n) begin
      c_reg <= '0;
    end else begin
      c_reg <= c_next;
    end
  end

  // Nonvolatile cells, untouched by reset
  always_ff @(posedge clk) begin
    if (nv_we) begin
      nv_cols[nv_addr] <= nv_wdata;
    end
    if (lock_set) begin
      nv_lock <= 1'b1;
    end else if (lock_clr) begin
      nv_lock <= 1'b0;
    end
    if (sig_we) begin
      nv_sig <= sig_wdata;
    end
  end

  assign readout_lock_bit = nv_lock;
  assign user_signature_word = nv_sig;
  assign nv_busy = c_reg.erasing;

endmodule
`default_nettype wire

/* File: tb/jcp_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module jcp_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [jcp_pkg::BSR_LEN-1:0] pins_in,
  input wire logic [jcp_pkg::BSR_LEN-1:0] pins_out,
  input wire logic readout_lock_bit,
  input wire logic [jcp_pkg::SIG_LEN-1:0] user_signature_word,
  input wire logic nv_busy
);
  // ----------------------------------------
  // Erase length counter
  // ----------------------------------------
  logic [11:0] busy_cnt_reg;
  // Counts clk cycles of one erase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt_reg <= 12'h000;
    end else if (nv_busy) begin
      busy_cnt_reg <= busy_cnt_reg + 12'h001;
    end else begin
      busy_cnt_reg <= 12'h000;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_tms_high5;
    tms [*5];
  endsequence
  property p_tdo_quiet;
    @(posedge tck) disable iff (!rst_n) !tdo_oe |-> !tdo;
  endproperty
  property p_shift_entry;
    @(posedge tck) disable iff (!rst_n) tdo_oe |-> !$past(tms);
  endproperty
  property p_shift_exit;
    @(posedge tck) disable iff (!rst_n) $fell(tdo_oe) |-> $past(tms);
  endproperty
  property p_tms_reset;
    @(posedge tck) disable iff (!rst_n) s_tms_high5 |=> !tdo_oe;
  endproperty
  property p_bsr_update;
    @(posedge tck) disable iff (!rst_n) $changed(pins_out) |-> !tdo_oe && !$past(tdo_oe);
  endproperty
  property p_lock_clear;
    @(posedge clk) disable iff (!rst_n) $fell(readout_lock_bit) |-> nv_busy || $past(nv_busy);
  endproperty
  property p_lock_set;
    @(posedge clk) disable iff (!rst_n) $rose(readout_lock_bit) |-> !$past(nv_busy);
  endproperty
  property p_erase_len;
    @(posedge clk) disable iff (!rst_n) $fell(nv_busy) |-> busy_cnt_reg == 12'h400;
  endproperty
  property p_busy_max;
    @(posedge clk) disable iff (!rst_n) busy_cnt_reg <= 12'h400;
  endproperty
  a_tdo_quiet: assert property (p_tdo_quiet) else $error("tdo not low outside shift");
  a_shift_entry: assert property (p_shift_entry) else $error("shift without tms low");
  a_shift_exit: assert property (p_shift_exit) else $error("shift left with tms low");
  a_tms_reset: assert property (p_tms_reset) else $error("tms high did not reset");
  a_bsr_update: assert property (p_bsr_update) else $error("pins_out moved in shift");
  a_lock_clear: assert property (p_lock_clear) else $error("lock cleared without erase");
  a_lock_set: assert property (p_lock_set) else $error("lock set during erase");
  a_erase_len: assert property (p_erase_len) else $error("erase length wrong");
  a_busy_max: assert property (p_busy_max) else $error("erase too long");
endmodule
bind jcp_port jcp_asserts i_asserts (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms),
  .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pins_in(pins_in), .pins_out(pins_out),
  .readout_lock_bit(readout_lock_bit), .user_signature_word(user_signature_word),
  .nv_busy(nv_busy));
`default_nettype wire

/* File: tb/jcp_host.sv */
`timescale 1ns/1ns
`default_nettype none
module jcp_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  // Test clock stands low between steps
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One tck period; inputs change after falling, tdo read at rising
  task automatic step(input logic t, input logic d, output logic o);
    tms = t;
    tdi = d;
    #16;
    o = tdo;
    tck = 1'b1;
    #16;
    tck = 1'b0;
  endtask
  // Idle steps; unused tdi toggles so stale data is never seen
  task automatic idle(input logic t, input int n);
    logic o;
    for (int i = 0; i < n; i++) begin
      step(t, ~tdi, o);
    end
  endtask
  // From Run-Test/Idle: scan n bits lsb first, back to idle and wait
  task automatic scan(input logic ir, input int n, input logic [127:0] din,
      output logic [127:0] dout);
    logic o;
    dout = '0;
    idle(1'b1, ir ? 2 : 1);
    idle(1'b0, 2);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    idle(1'b1, 1);
    idle(1'b0, 17);
  endtask
endmodule
`default_nettype wire

/* File: tb/test_jtag_config_programming_port.sv */
`timescale 1ns/1ns
`default_nettype none
module test_jtag_config_programming_port;
  logic clk, rst_n, tck, tms, tdi, tdo, tdo_oe, lock, busy;
  logic [7:0] pins_in, pins_out;
  logic [31:0] sig;
  logic [127:0] dout;
  int error_cnt = 0;
  int check_count = 0;
  localparam logic [88:0] COL = 89'h1_a5_5aa5_c33c_0ff0_1234_5678;
  localparam logic [88:0] COL2 = 89'h0_3c_a55a_f00f_8765_4321_9abc;
  localparam logic [88:0] COL3 = 89'h1_0f_f00f_1e1e_2d2d_3c3c_4b4b;
  jcp_port i_dut (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe), .pins_in(pins_in), .pins_out(pins_out), .readout_lock_bit(lock),
    .user_signature_word(sig), .nv_busy(busy));
  jcp_host i_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  // ----------------------------------------
  // Clock and helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ir(input logic [7:0] c);
    i_host.scan(1'b1, 8, {120'h0, c}, dout);
  endtask
  task automatic dr(input int n, input logic [127:0] d);
    i_host.scan(1'b0, n, d, dout);
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_bypass;
    logic [7:0] codes [3] = '{8'h80, 8'hc3, 8'hff};
    for (int i = 0; i < 3; i++) begin
      ir(codes[i]);
      check(dout, 128'h16);
      dr(3, 128'h5);
      check(dout, 128'h2);
    end
  endtask
  task automatic t_erase;
    int n;
    n = 0;
    ir(8'h15);
    fork
      ir(8'h03);
      for (int i = 0; i < 1300; i++) begin
        @(negedge clk);
        if (busy === 1'b1) n++;
      end
    join
    check(n, 128'h400);
    check({lock, sig}, 0);
  endtask
  task automatic t_verify(input logic [88:0] exp);
    ir(8'h01);
    dr(10, 128'h005);
    ir(8'h0a);
    ir(8'h02);
    dr(89, 0);
    check(dout, {39'h0, exp});
  endtask
  task automatic t_sig_read;
    ir(8'h17);
    dr(32, 0);
    check(dout, 128'h1234_5678);
  endtask
  // Reset for 20 cycles with the test clock stepping, then read the ID
  task automatic t_reset;
    @(negedge clk);
    rst_n = 1'b0;
    fork
      repeat (20) @(negedge clk);
      i_host.idle(1'b1, 5);
    join
    rst_n = 1'b1;
    i_host.idle(1'b1, 5);
    i_host.idle(1'b0, 1);
    check(tdo_oe, 0);
    dr(32, 0);
    check(dout, {96'h0, jcp_pkg::ID_VALUE});
  endtask
  // Every boundary instruction captures the pins and updates the outputs
  task automatic t_boundary;
    logic [7:0] codes [3] = '{8'h1c, 8'h00, 8'h2c};
    logic [7:0] pins [3] = '{8'ha5, 8'h69, 8'h0f};
    logic [7:0] upd [3] = '{8'h3c, 8'h5a, 8'hc3};
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      pins_in = pins[i];
      ir(codes[i]);
      dr(8, {120'h0, upd[i]});
      check(dout, {120'h0, pins[i]});
      check(pins_out, upd[i]);
    end
  endtask
  // Signature write refused while disabled, then one column programmed
  task automatic t_program;
    i_host.idle(1'b1, 5);
    i_host.idle(1'b0, 1);
    ir(8'h1a);
    dr(32, 128'hdead_beef);
    check(sig, 0);
    ir(8'h15);
    ir(8'h01);
    dr(10, 128'h005);
    ir(8'h02);
    dr(89, {39'h0, COL});
    ir(8'h07);
    t_verify(COL);
  endtask
  // Program and verify two columns with the auto-incrementing codes
  task automatic t_incr;
    ir(8'h01);
    dr(10, 128'h006);
    ir(8'h02);
    dr(89, {39'h0, COL2});
    ir(8'h27);
    ir(8'h02);
    dr(89, {39'h0, COL3});
    ir(8'h27);
    ir(8'h01);
    dr(10, 128'h006);
    for (int i = 0; i < 2; i++) begin
      ir(8'h2a);
      ir(8'h02);
      dr(89, 0);
      check(dout, {39'h0, (i == 0) ? COL2 : COL3});
    end
    ir(8'h01);
    dr(10, 0);
    check(dout, 128'h008);
  endtask
  // Signature written and read back
  task automatic t_sig_write;
    ir(8'h1a);
    dr(32, 128'h1234_5678);
    check(sig, 32'h1234_5678);
    t_sig_read();
  endtask
  // Lock refused once disabled, then set; readback blanked, signature kept
  task automatic t_lock;
    ir(8'h1e);
    ir(8'h09);
    check(lock, 0);
    ir(8'h15);
    ir(8'h09);
    check(lock, 1);
    t_verify(89'h0);
    t_sig_read();
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    pins_in = 8'ha5;
    t_reset();
    t_bypass();
    t_boundary();
    t_erase();
    t_program();
    t_incr();
    t_sig_write();
    t_lock();
    t_reset();
    check({lock, sig}, {1'b1, 32'h1234_5678});
    t_erase();
    print_verdict();
  end
  // Cuts a hang short
  initial begin
    #1000000;
    error_cnt++;
    print_verdict();
  end
endmodule
`default_nettype wire
